// ### pkg/csrc_pkg.sv
package csrc_pkg;
    localparam int NUM_CS = 11;
    localparam int STRAP_W = 8;
    localparam int REG_W = 16;
    localparam int SEL_W = 5;

    // Software register select codes
    localparam logic [4:0] SEL_PA_LO = 5'h00;
    localparam logic [4:0] SEL_PA_HI = 5'h01;
    localparam logic [4:0] SEL_BOOT_BASE = 5'h02;
    localparam logic [4:0] SEL_BOOT_OPT = 5'h03;
    localparam logic [4:0] SEL_BASE0 = 5'h04;
    localparam logic [4:0] SEL_OPT0 = 5'h0F;

    // Pin assignment field encodings
    localparam logic [1:0] PA_DISCRETE = 2'h0;
    localparam logic [1:0] PA_ALT = 2'h1;
    localparam logic [1:0] PA_CS8 = 2'h2;
    localparam logic [1:0] PA_CS16 = 2'h3;
    localparam int PA_BOOT_LSB = 0;
    localparam int PA_LO_CS_FIRST = 2;
    localparam int PA_LO_CS_COUNT = 5;

    // Base register layout
    localparam int BASE_ADDR_MSB = 15;
    localparam int BASE_ADDR_LSB = 3;
    localparam int BLK_MSB = 2;
    localparam int BLK_LSB = 0;
    localparam logic [2:0] BLK_2K = 3'h0;
    localparam logic [2:0] BLK_1M = 3'h7;

    // Option register layout
    localparam int OPT_MODE = 15;
    localparam int OPT_BYTE_MSB = 14;
    localparam int OPT_BYTE_LSB = 13;
    localparam int OPT_RW_MSB = 12;
    localparam int OPT_RW_LSB = 11;
    localparam int OPT_STRB = 10;
    localparam int OPT_ACK_MSB = 9;
    localparam int OPT_ACK_LSB = 6;
    localparam int OPT_SPACE_MSB = 5;
    localparam int OPT_SPACE_LSB = 4;
    localparam int OPT_IPL_MSB = 3;
    localparam int OPT_IPL_LSB = 1;
    localparam int OPT_AVEC = 0;

    localparam logic [1:0] SPACE_CPU = 2'h0;
    localparam logic [1:0] SPACE_USER = 2'h1;
    localparam logic [1:0] SPACE_SUP = 2'h2;
    localparam logic [1:0] SPACE_SU = 2'h3;
    localparam logic [1:0] RW_RSVD = 2'h0;
    localparam logic [1:0] RW_READ = 2'h1;
    localparam logic [1:0] RW_WRITE = 2'h2;
    localparam logic [1:0] RW_BOTH = 2'h3;
    localparam logic [2:0] FC_CPU = 3'h7;

    // Reset values
    localparam logic [15:0] PA_LO_RST = 16'h0557;
    localparam logic [15:0] PA_HI_RST = 16'h0555;
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam logic [15:0] OPT_RST = 16'h0000;
    localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
    localparam logic [15:0] BOOT_OPT_RST = 16'h7B70;
    localparam logic [7:0] STRAP_RST = 8'hFF;
endpackage

// ### rtl/csrc_strap_sync.sv
`timescale 1ns/1ps
module csrc_strap_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pin side
    input wire logic [W-1:0] pin_in,
    // Filtered level
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;

    // No reset on the chain so it keeps tracking the pins while reset is held
    always_ff @(posedge clk) begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // A bit changes only when the second and third stages agree; left unreset so
    // the level seen at the release edge is what the pins held during reset
    always_ff @(posedge clk) begin
        level_r <= (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
    end

    assign level_out = level_r;
endmodule

// ### rtl/csrc_chip_select.sv
`timescale 1ns/1ps
// Operation
// - Reset loads a one into the low bit of the general select pin-assignment fields for selects 0 to 10, select 10 included.
// - Data lines 7 to 1 sampled during reset set the high bits of the general fields.
// - Data lines are weakly pulled high during reset so chip-select use is the default.
// - General select byte-enable fields reset to disabled so they stay inert until set up.
// - General selects reset to base zero, 2K block, async, rw reserved, AS, no wait, CPU space.
// - Reset sets the high bit of the boot pin-assignment field so boot acts as a select.
// - Boot byte-enable resets to both bytes so boot is live without software.
// - Data line 0 sampled during reset picks an 8-bit boot port when low, 16-bit when high.
// - Data line 0 is weakly pulled high during reset so a 16-bit boot port is the default.
// - Boot base resets to zero so the first access to address zero asserts boot select.
// - Boot block size resets to one megabyte.
// - Boot option resets to async, read/write, AS, 13 waits, S/U space, any level, ext vector.
// - On reset release the boot byte-enable field holds binary 11.
// - On an 8-bit port any byte-enable value other than 00 enables the select.
module csrc_chip_select
    import csrc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Data pins used as straps
    input wire logic [csrc_pkg::STRAP_W-1:0] data_in,
    output logic [csrc_pkg::STRAP_W-1:0] data_pull_en,
    output logic cfg_ready,
    // Software register port
    input wire logic sw_wr,
    input wire logic [csrc_pkg::SEL_W-1:0] sw_sel,
    input wire logic [csrc_pkg::REG_W-1:0] sw_wdata,
    output logic [csrc_pkg::REG_W-1:0] sw_rdata,
    // Processor bus
    input wire logic [23:0] bus_addr,
    input wire logic [2:0] bus_fc,
    input wire logic bus_read,
    input wire logic bus_word,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    // Select outputs
    output logic [csrc_pkg::NUM_CS-1:0] cs_b,
    output logic boot_select_out_b
);
    import csrc_pkg::*;

    logic [STRAP_W-1:0] strap;
    logic init_r;
    logic [REG_W-1:0] pin_assign_reg_lo_r;
    logic [REG_W-1:0] pin_assign_reg_hi_r;
    logic [REG_W-1:0] boot_base_reg_r;
    logic [REG_W-1:0] boot_option_reg_r;
    logic [REG_W-1:0] select_base_reg_r [NUM_CS];
    logic [REG_W-1:0] select_option_reg_r [NUM_CS];
    logic [REG_W-1:0] rdata_nxt;
    logic [REG_W-1:0] sw_rdata_r;
    logic [NUM_CS-1:0] cs_hit;
    logic [NUM_CS-1:0] cs_b_r;
    logic boot_hit;
    logic boot_b_r;
    logic [1:0] boot_field;

    csrc_strap_sync #(
        .W(STRAP_W)
    ) u_strap (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in(data_in),
        .level_out(strap)
    );

    // Which strap line feeds each general select's high field bit
    function automatic int strap_line(input int ch);
        if (ch < 3) begin
            return 1;
        end else if (ch < 5) begin
            return ch - 1;
        end else begin
            return (ch > 9) ? 7 : ch - 3;
        end
    endfunction

    function automatic logic [1:0] pa_field(input logic [REG_W-1:0] lo,
                                            input logic [REG_W-1:0] hi, input int ch);
        if (ch < PA_LO_CS_COUNT) begin
            return lo[PA_LO_CS_FIRST + 2*ch +: 2];
        end else begin
            return hi[2*(ch - PA_LO_CS_COUNT) +: 2];
        end
    endfunction

    // Address, space, direction, byte and strobe match for one select
    function automatic logic sel_match(input logic [REG_W-1:0] base,
                                       input logic [REG_W-1:0] opt, input logic [1:0] pa);
        logic [12:0] mask;
        logic [1:0] bytes;
        logic [1:0] space;
        logic [2:0] irq_level_match;
        logic addr_ok;
        logic space_ok;
        logic rw_ok;
        logic byte_ok;
        logic strb_ok;
        mask = 13'h1FFF;
        bytes = opt[OPT_BYTE_MSB:OPT_BYTE_LSB];
        space = opt[OPT_SPACE_MSB:OPT_SPACE_LSB];
        irq_level_match = opt[OPT_IPL_MSB:OPT_IPL_LSB];
        case (base[BLK_MSB:BLK_LSB])
            3'h0: mask = 13'h1FFF;
            3'h1: mask = 13'h1FFC;
            3'h2: mask = 13'h1FF8;
            3'h3: mask = 13'h1FE0;
            3'h4: mask = 13'h1FC0;
            3'h5: mask = 13'h1F80;
            3'h6: mask = 13'h1F00;
            default: mask = 13'h1E00;
        endcase
        addr_ok = ((bus_addr[23:11] ^ base[BASE_ADDR_MSB:BASE_ADDR_LSB]) & mask) == 13'h0000;
        case (space)
            SPACE_CPU: space_ok = (bus_fc == FC_CPU)
                && (irq_level_match == 3'h0 || irq_level_match == bus_addr[3:1]);
            SPACE_USER: space_ok = !bus_fc[2];
            SPACE_SUP: space_ok = bus_fc[2] && bus_fc != FC_CPU;
            default: space_ok = bus_fc != FC_CPU;
        endcase
        case (opt[OPT_RW_MSB:OPT_RW_LSB])
            RW_READ: rw_ok = bus_read;
            RW_WRITE: rw_ok = !bus_read;
            RW_BOTH: rw_ok = 1'b1;
            default: rw_ok = 1'b0;
        endcase
        if (pa == PA_CS16) begin
            byte_ok = (bytes[1] && (!bus_addr[0] || bus_word))
                || (bytes[0] && (bus_addr[0] || bus_word));
        end else begin
            byte_ok = bytes != 2'h0;
        end
        strb_ok = opt[OPT_STRB] ? data_strobe : addr_strobe;
        return pa[1] && addr_ok && space_ok && rw_ok && byte_ok && strb_ok;
    endfunction

    // Goes high at the first edge after release; straps land on that same edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_r <= 1'b0;
        end else begin
            init_r <= 1'b1;
        end
    end

    // Pull-ups stay on until the straps have been taken
    assign data_pull_en = init_r ? {STRAP_W{1'b0}} : {STRAP_W{1'b1}};
    assign cfg_ready = init_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_assign_reg_lo_r <= PA_LO_RST;
            pin_assign_reg_hi_r <= PA_HI_RST;
        end else if (!init_r) begin
            pin_assign_reg_lo_r[PA_BOOT_LSB] <= strap[0];
            for (int c = 0; c < NUM_CS; c++) begin
                if (c < PA_LO_CS_COUNT) begin
                    pin_assign_reg_lo_r[PA_LO_CS_FIRST + 2*c + 1] <= strap[strap_line(c)];
                end else begin
                    pin_assign_reg_hi_r[2*(c - PA_LO_CS_COUNT) + 1] <= strap[strap_line(c)];
                end
            end
        end else if (sw_wr && sw_sel == SEL_PA_LO) begin
            pin_assign_reg_lo_r <= sw_wdata;
        end else if (sw_wr && sw_sel == SEL_PA_HI) begin
            pin_assign_reg_hi_r <= sw_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_base_reg_r <= BOOT_BASE_RST;
            boot_option_reg_r <= BOOT_OPT_RST;
        end else if (init_r && sw_wr && sw_sel == SEL_BOOT_BASE) begin
            boot_base_reg_r <= sw_wdata;
        end else if (init_r && sw_wr && sw_sel == SEL_BOOT_OPT) begin
            boot_option_reg_r <= sw_wdata;
        end
    end

    generate
        for (genvar g = 0; g < NUM_CS; g++) begin : g_cs
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    select_base_reg_r[g] <= BASE_RST;
                    select_option_reg_r[g] <= OPT_RST;
                end else if (init_r && sw_wr && sw_sel == SEL_BASE0 + SEL_W'(g)) begin
                    select_base_reg_r[g] <= sw_wdata;
                end else if (init_r && sw_wr && sw_sel == SEL_OPT0 + SEL_W'(g)) begin
                    select_option_reg_r[g] <= sw_wdata;
                end
            end
            assign cs_hit[g] = sel_match(select_base_reg_r[g], select_option_reg_r[g],
                pa_field(pin_assign_reg_lo_r, pin_assign_reg_hi_r, g));
        end
    endgenerate

    assign boot_field = pin_assign_reg_lo_r[PA_BOOT_LSB +: 2];
    assign boot_hit = sel_match(boot_base_reg_r, boot_option_reg_r, boot_field);

    // Registered selects: one cycle behind the strobes, held off until straps are in
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_b_r <= {NUM_CS{1'b1}};
            boot_b_r <= 1'b1;
        end else begin
            cs_b_r <= init_r ? ~cs_hit : {NUM_CS{1'b1}};
            boot_b_r <= !(init_r && boot_hit);
        end
    end

    assign cs_b = cs_b_r;
    assign boot_select_out_b = boot_b_r;

    always_comb begin
        rdata_nxt = 16'h0000;
        if (sw_sel == SEL_PA_LO) begin
            rdata_nxt = pin_assign_reg_lo_r;
        end else if (sw_sel == SEL_PA_HI) begin
            rdata_nxt = pin_assign_reg_hi_r;
        end else if (sw_sel == SEL_BOOT_BASE) begin
            rdata_nxt = boot_base_reg_r;
        end else if (sw_sel == SEL_BOOT_OPT) begin
            rdata_nxt = boot_option_reg_r;
        end else if (sw_sel >= SEL_BASE0 && sw_sel < SEL_OPT0) begin
            rdata_nxt = select_base_reg_r[4'(sw_sel - SEL_BASE0)];
        end else if (sw_sel >= SEL_OPT0 && sw_sel < SEL_OPT0 + SEL_W'(NUM_CS)) begin
            rdata_nxt = select_option_reg_r[4'(sw_sel - SEL_OPT0)];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_rdata_r <= 16'h0000;
        end else begin
            sw_rdata_r <= rdata_nxt;
        end
    end

    assign sw_rdata = sw_rdata_r;
endmodule

// ### tb/csrc_chip_select_asserts.sv
`timescale 1ns/1ps
module csrc_chk
    import csrc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Strap side
    input wire logic [7:0] data_pull_en,
    input wire logic cfg_ready,
    // Software port
    input wire logic sw_wr,
    input wire logic [4:0] sw_sel,
    input wire logic [15:0] sw_rdata,
    // Bus and selects
    input wire logic [23:0] bus_addr,
    input wire logic [2:0] bus_fc,
    input wire logic addr_strobe,
    input wire logic [10:0] cs_b,
    input wire logic boot_select_out_b
);
    logic wrote_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) wrote_r <= 1'b0;
        else if (sw_wr && cfg_ready) wrote_r <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    release_seq_a: assert property ($rose(rst_b) |-> data_pull_en == 8'hFF && !cfg_ready
        ##1 data_pull_en == 8'h00 && cfg_ready) else $error("bad release sequence");
    no_early_sel_a: assert property (!cfg_ready |-> &cs_b && boot_select_out_b)
        else $error("select before configuration");
    gen_inert_a: assert property (!wrote_r |-> &cs_b)
        else $error("general select without setup");
    ready_hold_a: assert property (cfg_ready |=> cfg_ready && data_pull_en == 8'h00)
        else $error("ready or pulls changed");
    // Boot checks rely on software leaving the boot registers untouched
    boot_cause_a: assert property (!boot_select_out_b |-> $past(addr_strobe)
        && $past(bus_addr[23:20]) == 4'h0 && $past(bus_fc) != FC_CPU) else $error("boot without match");
    boot_fires_a: assert property ($past(addr_strobe) && $past(bus_addr[23:20]) == 4'h0
        && $past(bus_fc) != FC_CPU && $past(cfg_ready) |-> !boot_select_out_b)
        else $error("boot missed");
    boot_opt_a: assert property ($past(cfg_ready) && $past(sw_sel) == SEL_BOOT_OPT
        |-> sw_rdata == BOOT_OPT_RST) else $error("boot option value");
    boot_base_a: assert property ($past(cfg_ready) && $past(sw_sel) == SEL_BOOT_BASE
        |-> sw_rdata == BOOT_BASE_RST) else $error("boot base value");
    boot_field_a: assert property ($past(cfg_ready) && $past(sw_sel) == SEL_PA_LO
        |-> sw_rdata[2:1] == 2'h3) else $error("pin field high or low bit");
    strap_hold_a: assert property ($past(cfg_ready, 2) && $past(sw_sel, 2) == SEL_PA_LO
        && $past(sw_sel) == SEL_PA_LO && !$past(sw_wr) |-> $stable(sw_rdata))
        else $error("strap field moved");
    cover property (!boot_select_out_b);
    cover property (!cs_b[0]);
    cover property ($rose(cfg_ready));
endmodule

// ### tb/csrc_ext_dev.sv
`timescale 1ns/1ps
module csrc_ext_dev (
    // Strap control from the bench
    input wire logic drive,
    input wire logic [7:0] strap,
    // Device pull-ups
    input wire logic [7:0] pull_en,
    // Resolved data lines
    output logic [7:0] data
);
    // Released lines without pull show the inverse so no stale level passes
    assign data = drive ? strap : (pull_en | ~strap);
endmodule

// ### tb/csrc_chip_select_tb.sv
`timescale 1ns/1ps
module csrc_chip_select_tb;
    import csrc_pkg::*;
    logic clk, rst_b, sw_wr, bus_read, bus_word, addr_strobe, data_strobe, drive, cfg_ready;
    logic boot_select_out_b;
    logic [4:0] sw_sel;
    logic [15:0] sw_wdata, sw_rdata;
    logic [23:0] bus_addr, a;
    logic [2:0] bus_fc;
    logic [7:0] strap, s, data_in, data_pull_en;
    logic [10:0] cs_b;
    logic [31:0] rng = 32'h0AE60252;
    logic [31:0] r;
    logic [2:0] fcs [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    int err_total = 0;
    int total_checks = 0;
    csrc_chip_select csrc_chip_select_i (.clk(clk), .rst_b(rst_b), .data_in(data_in),
        .data_pull_en(data_pull_en), .cfg_ready(cfg_ready), .sw_wr(sw_wr), .sw_sel(sw_sel),
        .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .bus_addr(bus_addr), .bus_fc(bus_fc),
        .bus_read(bus_read), .bus_word(bus_word), .addr_strobe(addr_strobe),
        .data_strobe(data_strobe), .cs_b(cs_b), .boot_select_out_b(boot_select_out_b));
    csrc_ext_dev csrc_ext_dev_i (.drive(drive), .strap(strap), .pull_en(data_pull_en),
        .data(data_in));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [15:0] exp_pa(input logic [7:0] v, input bit hi);
        logic [15:0] e;
        int ln;
        e = hi ? 16'h0000 : {14'h0000, 1'b1, v[0]};
        for (int c = 0; c < 11; c++) begin
            ln = c < 3 ? 1 : c < 5 ? c - 1 : c > 9 ? 7 : c - 3;
            if ((c > 4) == hi) e[(hi ? 2 * (c - 5) : 2 * c + 2) +: 2] = {v[ln], 1'b1};
        end
        return e;
    endfunction
    function automatic logic [11:0] exp_sel(input logic [23:0] ad, input logic [2:0] fc, bit on);
        logic sp;
        sp = fc != 3'h7;
        return {!(ad[23:20] == 4'h0 && sp), 10'h3FF, !(on && ad[23:11] == 13'h0000 && sp)};
    endfunction
    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_sel(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t selects got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] sel, input logic [15:0] exp);
        @(posedge clk) sw_sel <= sel;
        @(posedge clk);
        #1 cmp_reg(sw_rdata, exp, "read");
    endtask
    task automatic wr(input logic [4:0] sel, input logic [15:0] val);
        @(posedge clk);
        sw_wr <= 1'b1;
        sw_sel <= sel;
        sw_wdata <= val;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    // Random width and direction: the boot select allows both and either port size
    task automatic acc(input logic [23:0] ad, input logic [2:0] fc, input logic [11:0] exp);
        r = xs();
        @(posedge clk);
        bus_addr <= ad;
        bus_fc <= fc;
        bus_read <= r[0];
        bus_word <= r[1];
        data_strobe <= r[2];
        addr_strobe <= 1'b1;
        @(posedge clk);
        #1 cmp_sel({boot_select_out_b, cs_b}, exp);
        @(posedge clk);
        addr_strobe <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    bit on;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (10000) @(posedge clk);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {rst_b, sw_wr, bus_read, bus_word, addr_strobe, data_strobe, drive} = 7'h00;
        {sw_sel, sw_wdata, bus_addr, bus_fc, strap} = '0;
        for (int t = 0; t < 4; t++) begin
            r = xs();
            s = t == 0 ? 8'hFF : t == 1 ? 8'h01 : t == 2 ? 8'h00 : r[7:0];
            @(posedge clk);
            rst_b <= 1'b0;
            drive <= t != 0;
            strap <= s;
            repeat (20) @(posedge clk);
            #1 cmp_sel({boot_select_out_b, cs_b}, 12'hFFF);
            cmp_reg({7'h00, cfg_ready, data_pull_en}, 16'h00FF, "reset pulls");
            @(posedge clk);
            rst_b <= 1'b1;
            @(posedge clk);
            drive <= 1'b0;
            #1 cmp_reg({7'h00, cfg_ready, data_pull_en}, 16'h0100, "released");
            rd(SEL_PA_LO, exp_pa(s, 1'b0));
            rd(SEL_PA_HI, exp_pa(s, 1'b1));
            rd(SEL_BOOT_BASE, BOOT_BASE_RST);
            rd(SEL_BOOT_OPT, BOOT_OPT_RST);
            for (int c = 0; c < 11; c++) begin
                rd(SEL_BASE0 + 5'(c), BASE_RST);
                rd(SEL_OPT0 + 5'(c), OPT_RST);
            end
            acc(24'h000000, 3'h6, exp_sel(24'h000000, 3'h6, 1'b0));
            acc(24'h0FFFFF, 3'h1, exp_sel(24'h0FFFFF, 3'h1, 1'b0));
            acc(24'h100000, 3'h5, exp_sel(24'h100000, 3'h5, 1'b0));
            acc(24'h000000, 3'h7, exp_sel(24'h000000, 3'h7, 1'b0));
            for (int k = 0; k < 8; k++) begin
                r = xs();
                a = {r[31] ? 4'h0 : r[23:20], r[19:0]};
                acc(a, fcs[r[27:24] % 5], exp_sel(a, fcs[r[27:24] % 5], 1'b0));
            end
            wr(SEL_BASE0, 16'h0000);
            wr(SEL_OPT0, 16'h7830);
            rd(SEL_OPT0, 16'h7830);
            on = s[1];
            acc(24'h000000, 3'h6, exp_sel(24'h000000, 3'h6, on));
            acc(24'h000800, 3'h5, exp_sel(24'h000800, 3'h5, on));
            wr(SEL_OPT0, 16'h7810);
            acc(24'h000000, 3'h1, exp_sel(24'h000000, 3'h1, on));
            acc(24'h000000, 3'h6, exp_sel(24'h000000, 3'h6, 1'b0));
            $display("strap set %0d done", t);
        end
        end_of_test();
    end
endmodule
bind csrc_chip_select csrc_chk csrc_chk_i (.clk(clk), .rst_b(rst_b),
    .data_pull_en(data_pull_en), .cfg_ready(cfg_ready), .sw_wr(sw_wr), .sw_sel(sw_sel),
    .sw_rdata(sw_rdata), .bus_addr(bus_addr), .bus_fc(bus_fc), .addr_strobe(addr_strobe),
    .cs_b(cs_b), .boot_select_out_b(boot_select_out_b));
